// ===== rtl/tcsf_pkg.sv
// Package for the timer channel status flag block.
// Holds register offsets, bit positions, reset values and counter limits.
package tcsf_pkg;
  localparam int          NUM_CH        = 6;
  localparam logic [3:0]  OFS_STATUS0   = 4'h0;
  localparam logic [3:0]  OFS_IRQ_EN    = 4'h6;
  localparam logic [3:0]  OFS_DTC_CTRL  = 4'h7;
  localparam int          BIT_DIR       = 7;
  localparam int          BIT_RSVD      = 6;
  localparam int          BIT_UNF       = 5;
  localparam int          BIT_OVF       = 4;
  localparam int          BIT_FLAGD     = 3;
  localparam logic [7:0]  STATUS_RST    = 8'hC0;
  localparam logic [7:0]  STATUS_RST_D  = 8'h40;
  localparam logic [15:0] CNT_MIN       = 16'h0000;
  localparam logic [15:0] CNT_MAX       = 16'hFFFF;
  localparam logic [5:0]  CH_WITH_D     = 6'h09;
endpackage : tcsf_pkg

// ===== rtl/tcsf_status.sv
// Status flags for six channels of a 16-bit timer: direction, underflow, overflow and flag D.
// Assumes the counters, general register D compare/capture and the transfer controller live outside
// and present per-channel events and levels synchronous to i_clk.
//
// Summary of operation
// - Channels 1,2,4,5 read direction bit 0 counting down, 1 counting up.
// - Channels 0 and 3 read direction position as a fixed reserved bit.
// - Bit six is reserved, reads 1, ignores writes.
// - Channels 1,2,4,5 in phase counting set underflow on wrap 0000 to FFFF.
// - Channels 0 and 3 hold underflow position reserved, write-proof.
// - Overflow flag sets when the counter wraps FFFF to 0000.
// - A flag clears on a zero write only after a read returned it as one.
// - Bits five to zero accept only zero writes; writing one changes nothing.
// - Channels 0,3 with register D as compare set flag D on counter match.
// - Channels 0,3 with register D as capture set flag D on capture.
// - Transfer controller activation by flag D with disable select zero clears flag D.
// - Channels 1,2,4,5 hold flag D position reserved, unmodifiable.
// - Six independent status registers, one per channel.
// - Overflow interrupt is raised only while flag and its enable are both one.
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module tcsf_status #(
  parameter int NCH = tcsf_pkg::NUM_CH
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic [3:0]       i_addr,
  input  wire logic [7:0]       i_wdata,
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  output var  logic [7:0]       o_rdata,
  input  wire logic [NCH*16-1:0] i_cnt_prev,
  input  wire logic [NCH*16-1:0] i_cnt_next,
  input  wire logic [NCH-1:0]   i_cnt_step,
  input  wire logic [NCH-1:0]   i_count_up,
  input  wire logic [NCH-1:0]   i_phase_mode,
  input  wire logic [NCH-1:0]   i_gd_is_capture,
  input  wire logic [NCH-1:0]   i_gd_match,
  input  wire logic [NCH-1:0]   i_gd_capture,
  input  wire logic [NCH-1:0]   i_dtc_act_d,
  output var  logic [NCH-1:0]   o_overflow_interrupt,
  output var  logic [NCH-1:0]   o_match_interrupt_d
);
  logic [7:0]     status_q   [NCH];
  logic [7:0]     status_d   [NCH];
  logic [7:0]     armed_q    [NCH];
  logic [7:0]     armed_d    [NCH];
  logic [NCH-1:0] ovf_ien_q;
  logic [NCH-1:0] gd_ien_q;
  logic [NCH-1:0] transfer_disable_select_q;
  logic [7:0]     rdata_q;
  logic [7:0]     rd_mux;
  logic [NCH-1:0] ovf_irq_d;
  logic [NCH-1:0] gd_irq_d;
  logic [NCH-1:0] unf_ev;
  logic [NCH-1:0] ovf_ev;
  logic [NCH-1:0] gd_ev;

  function automatic logic has_d(input int ch);
    has_d = tcsf_pkg::CH_WITH_D[ch];
  endfunction : has_d

  function automatic logic sel_ch(input logic [3:0] a, input int ch);
    sel_ch = (a == 4'(tcsf_pkg::OFS_STATUS0 + 4'(ch)));
  endfunction : sel_ch

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      wire logic [15:0] prev = i_cnt_prev[g*16 +: 16];
      wire logic [15:0] nxt  = i_cnt_next[g*16 +: 16];
      wire logic        wsel = i_wr && sel_ch(i_addr, g);
      wire logic        rsel = i_rd && sel_ch(i_addr, g);
      // A write clears only bits armed by an earlier read of one and written as zero.
      wire logic [7:0]  wclr = wsel ? (armed_q[g] & ~i_wdata) : 8'h00;
      assign unf_ev[g] = !has_d(g) && i_phase_mode[g] && i_cnt_step[g]
                         && prev == tcsf_pkg::CNT_MIN && nxt == tcsf_pkg::CNT_MAX;
      assign ovf_ev[g] = i_cnt_step[g] && prev == tcsf_pkg::CNT_MAX
                         && nxt == tcsf_pkg::CNT_MIN;
      assign gd_ev[g]  = has_d(g) && (i_gd_is_capture[g] ? i_gd_capture[g] : i_gd_match[g]);
      wire logic gd_dtc_clr = has_d(g) && i_dtc_act_d[g] && !transfer_disable_select_q[g];

      always_comb begin
        status_d[g] = status_q[g];
        status_d[g][tcsf_pkg::BIT_RSVD] = 1'b1;
        if (has_d(g)) begin
          // Direction and underflow positions are constant in these channels.
          status_d[g][tcsf_pkg::BIT_DIR] = 1'b0;
          status_d[g][tcsf_pkg::BIT_UNF] = 1'b0;
          status_d[g][tcsf_pkg::BIT_FLAGD] = gd_ev[g] ||
              (status_q[g][tcsf_pkg::BIT_FLAGD] && !wclr[tcsf_pkg::BIT_FLAGD] && !gd_dtc_clr);
        end else begin
          status_d[g][tcsf_pkg::BIT_DIR] = i_count_up[g];
          status_d[g][tcsf_pkg::BIT_UNF] = unf_ev[g] ||
              (status_q[g][tcsf_pkg::BIT_UNF] && !wclr[tcsf_pkg::BIT_UNF]);
          status_d[g][tcsf_pkg::BIT_FLAGD] = 1'b0;
        end
        status_d[g][tcsf_pkg::BIT_OVF] = ovf_ev[g] ||
            (status_q[g][tcsf_pkg::BIT_OVF] && !wclr[tcsf_pkg::BIT_OVF]);
        armed_d[g] = armed_q[g] & status_d[g];
        if (rsel) begin
          armed_d[g] = status_q[g] & status_d[g];
        end
        if (wsel) begin
          armed_d[g] = 8'h00;
        end
      end

      assign ovf_irq_d[g] = status_d[g][tcsf_pkg::BIT_OVF] && ovf_ien_q[g];
      assign gd_irq_d[g]  = status_d[g][tcsf_pkg::BIT_FLAGD] && gd_ien_q[g];

      // Six separate registers, each with its own storage and read arming.
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          status_q[g] <= has_d(g) ? tcsf_pkg::STATUS_RST_D : tcsf_pkg::STATUS_RST;
          armed_q[g]  <= 8'h00;
        end else begin
          status_q[g] <= status_d[g];
          armed_q[g]  <= armed_d[g];
        end
      end
    end
  endgenerate

  always_comb begin
    rd_mux = 8'h00;
    for (int c = 0; c < NCH; c++) begin
      if (sel_ch(i_addr, c)) begin
        rd_mux = status_q[c];
      end
    end
    if (i_addr == tcsf_pkg::OFS_IRQ_EN) begin
      rd_mux = {2'h0, 6'(ovf_ien_q)};
    end
    if (i_addr == tcsf_pkg::OFS_DTC_CTRL) begin
      rd_mux = {2'h0, 6'(transfer_disable_select_q)};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ovf_ien_q <= '0;
      gd_ien_q  <= '0;
      transfer_disable_select_q   <= '0;
    end else if (i_wr && i_addr == tcsf_pkg::OFS_IRQ_EN) begin
      ovf_ien_q <= NCH'(i_wdata);
      gd_ien_q  <= NCH'(i_wdata) & NCH'(tcsf_pkg::CH_WITH_D);
    end else if (i_wr && i_addr == tcsf_pkg::OFS_DTC_CTRL) begin
      transfer_disable_select_q   <= NCH'(i_wdata);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_q              <= 8'h00;
      o_overflow_interrupt <= '0;
      o_match_interrupt_d  <= '0;
    end else begin
      rdata_q              <= i_rd ? rd_mux : 8'h00;
      o_overflow_interrupt <= ovf_irq_d;
      o_match_interrupt_d  <= gd_irq_d;
    end
  end
  assign o_rdata = rdata_q;

  AST_RSVD_ONE: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 status_q[1][tcsf_pkg::BIT_RSVD]) else $error("reserved bit not one");
  AST_DIR_CH1: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 status_q[1][tcsf_pkg::BIT_DIR] == $past(i_count_up[1])) else $error("direction wrong");
  AST_DIR_CH0: assert property (@(posedge i_clk) disable iff (i_rst)
    !status_q[0][tcsf_pkg::BIT_DIR] && !status_q[0][tcsf_pkg::BIT_UNF]) else $error("ch0 reserved set");
  AST_UNF_SET: assert property (@(posedge i_clk) disable iff (i_rst)
    unf_ev[1] |=> status_q[1][tcsf_pkg::BIT_UNF]) else $error("underflow not set");
  AST_UNF_CH3: assert property (@(posedge i_clk) disable iff (i_rst)
    !status_q[3][tcsf_pkg::BIT_UNF]) else $error("ch3 underflow set");
  AST_OVF_SET: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_cnt_step[2] && i_cnt_prev[47:32] == 16'hFFFF && i_cnt_next[47:32] == 16'h0000)
    |=> status_q[2][tcsf_pkg::BIT_OVF]) else $error("overflow not set");
  sequence s_read_one_ch2;
    i_rd && i_addr == 4'h2 && status_q[2][tcsf_pkg::BIT_OVF];
  endsequence
  sequence s_write_zero_ch2;
    i_wr && i_addr == 4'h2 && !i_wdata[tcsf_pkg::BIT_OVF] && !ovf_ev[2];
  endsequence
  AST_CLR_SEQ: assert property (@(posedge i_clk) disable iff (i_rst)
    s_read_one_ch2 ##1 s_write_zero_ch2 |=> !status_q[2][tcsf_pkg::BIT_OVF]) else $error("flag not cleared");
  AST_NO_BLIND_CLR: assert property (@(posedge i_clk) disable iff (i_rst)
    (status_q[2][tcsf_pkg::BIT_OVF] && armed_q[2][tcsf_pkg::BIT_OVF] == 1'b0)
    |=> status_q[2][tcsf_pkg::BIT_OVF]) else $error("unarmed clear");
  AST_GD_SET: assert property (@(posedge i_clk) disable iff (i_rst)
    gd_ev[0] |=> status_q[0][tcsf_pkg::BIT_FLAGD]) else $error("flag D not set");
  AST_GD_DTC: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_dtc_act_d[3] && !transfer_disable_select_q[3] && !gd_ev[3]) |=> !status_q[3][tcsf_pkg::BIT_FLAGD])
    else $error("flag D not cleared by transfer");
  AST_GD_RSVD: assert property (@(posedge i_clk) disable iff (i_rst)
    !status_q[4][tcsf_pkg::BIT_FLAGD]) else $error("ch4 flag D set");
  AST_OVF_IRQ: assert property (@(posedge i_clk) disable iff (i_rst)
    o_overflow_interrupt[2] |-> status_q[2][tcsf_pkg::BIT_OVF]) else $error("irq without flag");
  AST_SET_WINS: assert property (@(posedge i_clk) disable iff (i_rst)
    (ovf_ev[5] && i_wr && i_addr == 4'h5) |=> status_q[5][tcsf_pkg::BIT_OVF]) else $error("set lost");

  // Fixed positions checked in further channels, not only in the one sampled above.
  AST_RSVD_ONE_CH0: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 status_q[0][tcsf_pkg::BIT_RSVD])
    else $error("ch0 reserved bit not one");
  AST_RSVD_ONE_CH3: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 status_q[3][tcsf_pkg::BIT_RSVD])
    else $error("ch3 reserved bit not one");
  AST_DIR_CH3: assert property (@(posedge i_clk) disable iff (i_rst)
    !status_q[3][tcsf_pkg::BIT_DIR])
    else $error("ch3 direction position set");
  AST_DIR_CH4: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 status_q[4][tcsf_pkg::BIT_DIR] == $past(i_count_up[4]))
    else $error("ch4 direction wrong");
  AST_DIR_CH5: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 status_q[5][tcsf_pkg::BIT_DIR] == $past(i_count_up[5]))
    else $error("ch5 direction wrong");
  AST_UNF_CH0: assert property (@(posedge i_clk) disable iff (i_rst)
    !status_q[0][tcsf_pkg::BIT_UNF])
    else $error("ch0 underflow set");
  AST_GD_RSVD_CH1: assert property (@(posedge i_clk) disable iff (i_rst)
    !status_q[1][tcsf_pkg::BIT_FLAGD])
    else $error("ch1 flag D set");
  AST_GD_RSVD_CH2: assert property (@(posedge i_clk) disable iff (i_rst)
    !status_q[2][tcsf_pkg::BIT_FLAGD])
    else $error("ch2 flag D set");
  AST_GD_RSVD_CH5: assert property (@(posedge i_clk) disable iff (i_rst)
    !status_q[5][tcsf_pkg::BIT_FLAGD])
    else $error("ch5 flag D set");
  AST_GD_IRQ_CH1: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_match_interrupt_d[1])
    else $error("ch1 flag D request raised");

  // Setting events in further channels, and no underflow outside phase mode.
  AST_UNF_NOPHASE: assert property (@(posedge i_clk) disable iff (i_rst)
    (!i_phase_mode[2] && !status_q[2][tcsf_pkg::BIT_UNF]) |=> !status_q[2][tcsf_pkg::BIT_UNF])
    else $error("underflow set outside phase mode");
  AST_OVF_SET_CH0: assert property (@(posedge i_clk) disable iff (i_rst)
    ovf_ev[0] |=> status_q[0][tcsf_pkg::BIT_OVF])
    else $error("ch0 overflow not set");
  AST_OVF_SET_CH1: assert property (@(posedge i_clk) disable iff (i_rst)
    ovf_ev[1] |=> status_q[1][tcsf_pkg::BIT_OVF])
    else $error("ch1 overflow not set");
  AST_OVF_SET_CH5: assert property (@(posedge i_clk) disable iff (i_rst)
    ovf_ev[5] |=> status_q[5][tcsf_pkg::BIT_OVF])
    else $error("ch5 overflow not set");
  AST_GD_SET_CH3: assert property (@(posedge i_clk) disable iff (i_rst)
    gd_ev[3] |=> status_q[3][tcsf_pkg::BIT_FLAGD])
    else $error("ch3 flag D not set");

  // Clearing needs a read of one first; a one written or an unarmed zero must not clear.
  AST_ONE_WRITE_KEEPS: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_wr && i_addr == 4'h1 && i_wdata[tcsf_pkg::BIT_OVF] && status_q[1][tcsf_pkg::BIT_OVF])
    |=> status_q[1][tcsf_pkg::BIT_OVF])
    else $error("one write cleared flag");
  AST_UNARMED_UNF: assert property (@(posedge i_clk) disable iff (i_rst)
    (status_q[1][tcsf_pkg::BIT_UNF] && !armed_q[1][tcsf_pkg::BIT_UNF]) |=> status_q[1][tcsf_pkg::BIT_UNF])
    else $error("underflow cleared without read");
  AST_UNARMED_OVF5: assert property (@(posedge i_clk) disable iff (i_rst)
    (status_q[5][tcsf_pkg::BIT_OVF] && !armed_q[5][tcsf_pkg::BIT_OVF]) |=> status_q[5][tcsf_pkg::BIT_OVF])
    else $error("ch5 overflow cleared without read");
  sequence s_read_one_unf_ch1;
    i_rd && i_addr == 4'h1 && status_q[1][tcsf_pkg::BIT_UNF];
  endsequence
  sequence s_write_zero_unf_ch1;
    i_wr && i_addr == 4'h1 && !i_wdata[tcsf_pkg::BIT_UNF] && !unf_ev[1];
  endsequence
  AST_CLR_SEQ_UNF: assert property (@(posedge i_clk) disable iff (i_rst)
    s_read_one_unf_ch1 ##1 s_write_zero_unf_ch1 |=> !status_q[1][tcsf_pkg::BIT_UNF])
    else $error("underflow not cleared");

  // Transfer controller clearing and its interaction with setting.
  AST_DTC_TRANSFER_DISABLE_SELECT: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_dtc_act_d[0] && transfer_disable_select_q[0] && status_q[0][tcsf_pkg::BIT_FLAGD]) |=> status_q[0][tcsf_pkg::BIT_FLAGD])
    else $error("flag D cleared with disable select set");
  AST_SET_WINS_D: assert property (@(posedge i_clk) disable iff (i_rst)
    (gd_ev[0] && i_dtc_act_d[0]) |=> status_q[0][tcsf_pkg::BIT_FLAGD])
    else $error("flag D set lost");

  // Requests follow their flags and enables.
  AST_OVF_IRQ_CH0: assert property (@(posedge i_clk) disable iff (i_rst)
    o_overflow_interrupt[0] |-> status_q[0][tcsf_pkg::BIT_OVF])
    else $error("ch0 irq without flag");
  AST_OVF_IRQ_RISE: assert property (@(posedge i_clk) disable iff (i_rst)
    (ovf_ev[2] && ovf_ien_q[2]) |=> o_overflow_interrupt[2])
    else $error("ch2 irq not raised");
  AST_GD_IRQ_FLAG: assert property (@(posedge i_clk) disable iff (i_rst)
    o_match_interrupt_d[0] |-> status_q[0][tcsf_pkg::BIT_FLAGD])
    else $error("flag D request without flag");

  // The read port answers one cycle after the strobe and is quiet otherwise.
  AST_RD_CH3: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_rd && i_addr == 4'h3) |=> o_rdata[tcsf_pkg::BIT_RSVD])
    else $error("ch3 read lost reserved one");
  AST_RDATA_IDLE: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data without read");
endmodule : tcsf_status
`default_nettype wire

// ===== tb/tcsf_status_bench.sv
// Bench for the channel status flags: bus tasks, a flag model and checks.
// Assumes the transfer model answers flag D requests.
`timescale 1ns/100ps
`default_nettype none
module tcsf_status_bench;
  logic        clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00, rdata;
  logic [95:0] prv = 96'h0, nxt = 96'h0;
  logic [5:0]  stp = 6'h00, up = 6'h36, ph = 6'h00, capm = 6'h08, mt = 6'h00, cp = 6'h00, act, ovi, mdi;
  int          n_mismatch = 0, checks_done = 0, cyc = 0, seed = 32'h9D1BE90B;
  int          ovf[6], unf[6], fd[6], arm[6];
  tcsf_status tcsf_status_i (.i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_cnt_prev(prv), .i_cnt_next(nxt), .i_cnt_step(stp), .i_count_up(up), .i_phase_mode(ph),
    .i_gd_is_capture(capm), .i_gd_match(mt), .i_gd_capture(cp), .i_dtc_act_d(act), .o_overflow_interrupt(ovi),
    .o_match_interrupt_d(mdi));
  tcsf_xfer_model tcsf_xfer_model_i (.i_clk(clk), .i_rst(rst), .i_req(mdi), .i_dis(6'h00), .o_act(act));
  initial forever #5 clk = ~clk;
  function automatic logic [7:0] exp_st(int c);
    if (c == 0 || c == 3) return {2'h1, 1'h0, ovf[c][0], fd[c][0], 3'h0};
    return {up[c], 1'h1, unf[c][0], ovf[c][0], 4'h0};
  endfunction : exp_st
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rd_chk(logic [3:0] a);
    logic [7:0] e;
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    // Taken at the sampling edge so that level inputs changed just before the read are seen.
    e = (a < 4'h6) ? exp_st(a) : 8'h00;
    #1 check(rdata, e);
    // A read only arms the flags that it saw at one.
    if (a < 4'h6) arm[a] = e[5:3];
  endtask : rd_chk
  task automatic wr_reg(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    if (a < 4'h6) begin
      if (arm[a][2] && !d[5]) unf[a] = 0;
      if (arm[a][1] && !d[4]) ovf[a] = 0;
      if (arm[a][0] && !d[3]) fd[a] = 0;
      arm[a] = 0;
    end
  endtask : wr_reg
  task automatic step_ch(int c, logic [15:0] p, logic [15:0] n);
    @(posedge clk);
    prv[c*16+:16] <= p;
    nxt[c*16+:16] <= n;
    stp[c] <= 1'h1;
    @(posedge clk);
    stp[c] <= 1'h0;
    if (p == tcsf_pkg::CNT_MAX && n == tcsf_pkg::CNT_MIN) ovf[c] = 1;
    if (p == tcsf_pkg::CNT_MIN && n == tcsf_pkg::CNT_MAX && ph[c] && c != 0 && c != 3) unf[c] = 1;
  endtask : step_ch
  task automatic d_ev(int c, logic is_cap);
    @(posedge clk);
    mt[c] <= !is_cap;
    cp[c] <= is_cap;
    @(posedge clk);
    mt[c] <= 1'h0;
    cp[c] <= 1'h0;
    if ((c == 0 || c == 3) && capm[c] == is_cap) fd[c] = 1;
  endtask : d_ev
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    for (int c = 0; c < 6; c++) rd_chk(4'(c));
    rd_chk(4'h9);
    up[2] <= 1'h0;
    rd_chk(4'h2);
    wr_reg(4'h6, 8'h04);
    for (int c = 0; c < 6; c++) step_ch(c, 16'hFFFF, 16'h0000);
    #1 check({2'h0, ovi}, 8'h04);
    ph <= 6'h03;
    for (int c = 0; c < 3; c++) step_ch(c, 16'h0000, 16'hFFFF);
    for (int c = 0; c < 6; c++) begin
      rd_chk(4'(c));
      wr_reg(4'(c), 8'($random(seed)) | 8'h3F);
      wr_reg(4'(c), 8'h00);
      rd_chk(4'(c));
      wr_reg(4'(c), 8'h00);
      rd_chk(4'(c));
    end
    check({2'h0, ovi}, 8'h00);
    d_ev(0, 1'h0);
    d_ev(1, 1'h0);
    d_ev(3, 1'h1);
    d_ev(0, 1'h1);
    for (int c = 0; c < 4; c++) rd_chk(4'(c));
    wr_reg(4'h7, 8'h00);
    wr_reg(4'h6, 8'h01);
    for (int i = 0; i < 10 && act[0] !== 1'h1; i++) @(negedge clk);
    check({7'h0, act[0]}, 8'h01);
    check({2'h0, mdi}, 8'h01);
    fd[0] = 0;
    repeat (2) @(posedge clk);
    rd_chk(4'h0);
    check({2'h0, mdi}, 8'h00);
    rd_chk(4'h3);
    // Read then clearing write back to back on the same register.
    step_ch(2, 16'hFFFF, 16'h0000);
    @(posedge clk);
    addr <= 4'h2;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    wr <= 1'h1;
    wdata <= 8'h00;
    #1 check(rdata, exp_st(2));
    @(posedge clk);
    wr <= 1'h0;
    ovf[2] = 0;
    rd_chk(4'h2);
    report_and_stop();
  end
endmodule : tcsf_status_bench
`default_nettype wire

// ===== tb/tcsf_xfer_model.sv
// Transfer controller model that answers flag D interrupt requests.
// Assumes one clock and a synchronous reset shared with the status block.
`timescale 1ns/100ps
`default_nettype none
module tcsf_xfer_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [5:0] i_req,
  input  wire logic [5:0] i_dis,
  output var  logic [5:0] o_act
);
  logic [5:0] req_q;
  // Acting only on a rising request keeps a slow clear from being answered twice.
  always_ff @(posedge i_clk) begin
    req_q <= i_rst ? 6'h00 : i_req;
    o_act <= i_rst ? 6'h00 : (i_req & ~req_q & ~i_dis);
  end
endmodule : tcsf_xfer_model
`default_nettype wire
